// ==== inc/pmas_pkg.sv ====
// Package with register map, field layout, timing and carrier types of the measurement sequencer.
package pmas_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index.
  localparam logic [3:0]  REG_SETUP_IDX      = 4'h1;
  localparam logic [3:0]  REG_BUSV_IDX       = 4'h5;
  localparam logic [3:0]  REG_TEMP_IDX       = 4'h6;
  localparam logic [3:0]  REG_CURR_IDX       = 4'h7;
  localparam logic [3:0]  REG_POWER_IDX      = 4'h8;
  localparam int          ADDR_LSB           = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Field layout and reset values of converter_setup.
  localparam int          MODE_MSB           = 15;
  localparam int          MODE_LSB           = 12;
  localparam int          VBCT_MSB           = 11;
  localparam int          VBCT_LSB           = 9;
  localparam int          SHCT_MSB           = 8;
  localparam int          SHCT_LSB           = 6;
  localparam int          TMCT_MSB           = 5;
  localparam int          TMCT_LSB           = 3;
  localparam int          NSMP_MSB           = 2;
  localparam int          NSMP_LSB           = 0;
  localparam logic [15:0] SETUP_RESET        = 16'hfb68;
  localparam int          TEMP_RES_LSB       = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode bits: bit 3 continuous, bit 2 temperature, bit 1 current, bit 0 bus.
  localparam int          MODE_CONT_BIT      = 3;
  localparam int          MODE_TEMP_BIT      = 2;
  localparam int          MODE_CURR_BIT      = 1;
  localparam int          MODE_BUS_BIT       = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing: clock rate and conversion durations in microseconds.
  localparam int          CLK_MHZ            = 250;
  localparam int          CT_US_0            = 50;
  localparam int          CT_US_1            = 84;
  localparam int          CT_US_2            = 150;
  localparam int          CT_US_3            = 280;
  localparam int          CT_US_4            = 540;
  localparam int          CT_US_5            = 1052;
  localparam int          CT_US_6            = 2074;
  localparam int          CT_US_7            = 4120;
  localparam int          US_CYCLES          = CLK_MHZ;

  typedef enum logic [1:0] {
    PMAS_CH_BUS  = 2'b00,
    PMAS_CH_CURR = 2'b01,
    PMAS_CH_TEMP = 2'b10
  } pmas_chan_e;

  typedef struct packed {
    logic [15:0] bus_voltage;
    logic [11:0] die_temperature;
    logic [15:0] current;
    logic [23:0] power;
  } pmas_results_s;

  typedef struct packed {
    logic [3:0] mode;
    logic [2:0] bus_voltage_conv_time;
    logic [2:0] shunt_voltage_conv_time;
    logic [2:0] temperature_conv_time;
    logic [2:0] sample_averaging_count;
  } pmas_setup_s;

endpackage : pmas_pkg

// ==== sim/pmas_frontend_model.sv ====
// Behavioural converter front end that feeds samples to the sequencer.
`timescale 1ns/1ps
module pmas_frontend_model (
  // Samples
  output logic [15:0] bus_o,
  output logic [15:0] shunt_o,
  output logic [11:0] temp_o
);
  initial begin
    bus_o   = 16'h0000;
    shunt_o = 16'h0000;
    temp_o  = 12'h000;
  end

  // Non-blocking so that a change made at a clock edge lands after that edge's sampling.
  task automatic set(input logic [15:0] b, input logic [15:0] s, input logic [11:0] t);
    bus_o   <= b;
    shunt_o <= s;
    temp_o  <= t;
  endtask : set
endmodule : pmas_frontend_model

// ==== sim/pmas_sequencer_assertions.sv ====
// Concurrent checks on the bus answers and the status of the sequencer.
`timescale 1ns/1ps
module pmas_chk
  import pmas_pkg::*;
#(
  parameter int US_DIV = US_CYCLES
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [5:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Samples and status
  input wire logic [15:0] bus_sample_i,
  input wire logic [15:0] shunt_sample_i,
  input wire logic [11:0] temp_sample_i,
  input wire logic        busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic       req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic       rd  = wb_ack_o && !wb_we_i;
  wire logic [3:0] idx = wb_adr_i[5:2];
  wire logic       wrm = req && wb_we_i && idx == REG_SETUP_IDX && wb_sel_i[1];
  wire logic [3:0] md  = wb_dat_i[15:12];
  //////////////////////////////////////////////////////////////////////
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  chk_ack_latency: assert property (req |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_result_width: assert property (rd && idx != REG_POWER_IDX
    |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_temp_low_zero: assert property (rd && idx == REG_TEMP_IDX |-> wb_dat_o[3:0] == 4'h0)
    else $error("temperature low bits not zero");
  chk_power_width: assert property (rd && idx == REG_POWER_IDX |-> wb_dat_o[31:24] == 8'h0)
    else $error("power above 24 bits");
  chk_unmapped_zero: assert property (rd && !(idx inside {4'h1, [4'h5:4'h8]})
    |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_shutdown_stop: assert property (wrm && md inside {4'h0, 4'h8} |-> ##[1:10] !busy_o)
    else $error("shutdown did not stop the sequencer");
  chk_trigger_start: assert property (wrm && !busy_o && md inside {4'h1, [4'h4:4'h7]}
    |-> ##[1:4] busy_o)
    else $error("trigger did not start a run");
  chk_reserved_idle: assert property (wrm && !busy_o && md inside {[4'h2:4'h3], [4'ha:4'hb]}
    |=> !busy_o [*8])
    else $error("reserved mode started a run");
  cover property (rd && idx == REG_POWER_IDX);
  cover property ($fell(busy_o));
  cover property (wrm && md == 4'hf);
endmodule : pmas_chk

bind pmas_sequencer pmas_chk #(.US_DIV(US_DIV)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus_sample_i(bus_sample_i),
  .shunt_sample_i(shunt_sample_i), .temp_sample_i(temp_sample_i), .busy_o(busy_o));

// ==== sim/pmas_sequencer_tb.sv ====
// Self-checking bench for the measurement sequencer and its registers.
`timescale 1ns/1ps
module pmas_sequencer_tb
  import pmas_pkg::*;
();
  localparam int DIV = 1;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        stb   = 1'b0;
  logic        we    = 1'b0;
  logic [5:0]  adr   = 6'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        busy;
  logic [15:0] bus_s;
  logic [15:0] sh_s;
  logic [11:0] tp_s;
  logic [15:0] e_bus = 16'h0;
  logic [15:0] e_cur = 16'h0;
  logic [11:0] e_tmp = 12'h0;
  int          mismatches = 0;
  int          n_checks   = 0;
  int          ct [8] = '{CT_US_0, CT_US_1, CT_US_2, CT_US_3, CT_US_4, CT_US_5, CT_US_6, CT_US_7};

  always #2 clk_i = ~clk_i;

  pmas_frontend_model fe (.bus_o(bus_s), .shunt_o(sh_s), .temp_o(tp_s));
  pmas_sequencer #(.US_DIV(DIV)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bus_sample_i(bus_s), .shunt_sample_i(sh_s), .temp_sample_i(tp_s), .busy_o(busy));
  //////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (mismatches == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic wb_xfer(input logic w, input logic [5:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      print_verdict();
    end
  endtask : wb_xfer

  task automatic wr(input logic [15:0] d);
    logic [31:0] q;
    wb_xfer(1'b1, 6'h04, 4'h3, {16'h0, d}, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 4'hf, 32'h0, q);
    check(nm, q, e);
  endtask : rdc

  // Busy may already be up when the write returns, so the count can fall short by two.
  task automatic busy_len(output int n);
    int k;
    k = 0;
    n = 0;
    while (busy !== 1'b1 && k < 8) begin
      @(posedge clk_i);
      k++;
    end
    while (busy === 1'b1 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      print_verdict();
    end
  endtask : busy_len

  task automatic run_time(input logic [15:0] s, input int lo, input int hi);
    int n;
    wr(s);
    busy_len(n);
    check("busy cycles", 32'(n >= lo && n <= hi), 32'h1);
  endtask : run_time

  task automatic upd(input logic [3:0] m);
    if (m[MODE_BUS_BIT]) e_bus = bus_s[15] ? 16'h0 : bus_s;
    if (m[MODE_CURR_BIT]) e_cur = sh_s;
    if (m[MODE_TEMP_BIT]) e_tmp = tp_s;
  endtask : upd

  task automatic results(input logic pw);
    logic [31:0] p;
    p = {16'h0, e_cur[15] ? -e_cur : e_cur} * {16'h0, e_bus};
    rdc("bus", 6'h14, {16'h0, e_bus});
    rdc("temp", 6'h18, {16'h0, e_tmp, 4'h0});
    rdc("current", 6'h1c, {16'h0, e_cur});
    if (pw) rdc("power", 6'h20, {8'h0, p[31:8]});
  endtask : results
  //////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [5:0]  a [6] = '{6'h14, 6'h18, 6'h1c, 6'h20, 6'h00, 6'h24};
    logic [31:0] q;
    rdc("setup", 6'h04, 32'h0000_fb68);
    for (int i = 0; i < 6; i++) rdc("reset value", a[i], 32'h0);
    wb_xfer(1'b1, 6'h14, 4'hf, 32'h0000_ffff, q);
    rdc("read only", 6'h14, 32'h0);
  endtask : t_reset

  task automatic t_setup();
    logic [31:0] q;
    int          n;
    wr(16'h0000);
    busy_len(n);
    check("busy off", 32'(busy), 32'h0);
    wb_xfer(1'b1, 6'h04, 4'h1, 32'h0000_ffff, q);
    rdc("setup lane", 6'h04, 32'h0000_00ff);
  endtask : t_setup

  task automatic t_reserved();
    logic [3:0] m [6] = '{4'h2, 4'h3, 4'ha, 4'hb, 4'h8, 4'h0};
    for (int i = 0; i < 6; i++) begin
      wr({m[i], 12'h000});
      repeat (20) @(posedge clk_i);
      check("idle", 32'(busy), 32'h0);
    end
  endtask : t_reserved

  task automatic t_times();
    int cur_t;
    for (int c = 0; c < 8; c++) begin
      run_time(16'h1000 | 16'(c << 9), ct[c] * DIV - 2, ct[c] * DIV + 8);
    end
    cur_t = (ct[2] + 2 * ct[1]) * DIV;
    run_time(16'h6088, cur_t - 2, cur_t + 12);
    run_time(16'h5001, 8 * ct[0] * DIV - 2, 8 * ct[0] * DIV + 32);
    run_time(16'h1003, 64 * ct[0] * DIV - 2, 64 * ct[0] * DIV + 200);
  endtask : t_times

  task automatic t_triggered();
    logic [3:0] m [5] = '{4'h7, 4'h1, 4'h4, 4'h5, 4'h6};
    int         n;
    for (int i = 0; i < 5; i++) begin
      fe.set((i == 1) ? 16'h8001 : 16'h0400 + 16'(i), 16'hfe00 + 16'(i), 12'hf80 + 12'(i));
      wr({m[i], 12'h000});
      busy_len(n);
      upd(m[i]);
      results(m[i] == 4'h7);
    end
  endtask : t_triggered

  task automatic t_continuous();
    logic [3:0] m [5] = '{4'h9, 4'hc, 4'hd, 4'he, 4'hf};
    int         n;
    for (int i = 0; i < 5; i++) begin
      fe.set(16'h0200 + 16'(i), 16'h0010 + 16'(i), 12'h100 + 12'(i));
      wr({m[i], 12'h000});
      repeat (300) @(posedge clk_i);
      fe.set(16'h0300 + 16'(i), 16'h0020 + 16'(i), 12'h200 + 12'(i));
      repeat (500) @(posedge clk_i);
      check("running", 32'(busy), 32'h1);
      upd(m[i]);
      results(m[i] == 4'hf);
      wr(16'h0000);
      busy_len(n);
    end
  endtask : t_continuous

  task automatic t_average();
    int n;
    fe.set(16'h0777, 16'h0011, 12'h011);
    wr(16'h1002);
    repeat (100) @(posedge clk_i);
    rdc("bus mid run", 6'h14, {16'h0, e_bus});
    busy_len(n);
    rdc("bus averaged", 6'h14, 32'h0000_0777);
  endtask : t_average

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_setup();
    t_reserved();
    t_times();
    t_triggered();
    t_continuous();
    t_average();
    print_verdict();
  end
endmodule : pmas_sequencer_tb

// ==== verilog/pmas_averager.sv ====
// Sample accumulator that yields the mean of a power-of-two number of signed samples.
`timescale 1ns/1ps
module pmas_averager
  import pmas_pkg::*;
#(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Samples
  input  wire logic         clear_i,
  input  wire logic         add_i,
  input  wire logic [W-1:0] sample_i,
  input  wire logic [3:0]   shift_i,
  // Result
  output logic [W-1:0]      mean_o
);

  logic signed [W+10:0] acc_q, acc_d;
  logic signed [W+10:0] shifted;

  always_comb begin
    acc_d = acc_q;
    if (clear_i) begin
      acc_d = '0;
    end else if (add_i) begin
      acc_d = acc_q + (W+11)'($signed(sample_i));
    end
    shifted = acc_q >>> shift_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= '0;
    end else begin
      acc_q <= acc_d;
    end
  end

  assign mean_o = shifted[W-1:0];

endmodule : pmas_averager

// ==== verilog/pmas_conv_timer.sv ====
// Conversion timer that turns a time code into a done pulse after the coded duration.
`timescale 1ns/1ps
module pmas_conv_timer
  import pmas_pkg::*;
#(
  parameter int US_DIV = US_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Control
  input  wire logic       start_i,
  input  wire logic [2:0] code_i,
  output logic            done_o
);

  logic [7:0]  pre_q, pre_d;
  logic [12:0] us_q, us_d;
  logic [12:0] target;
  logic        run_q, run_d;
  logic        done_q, done_d;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (code_i)
      3'h0:    target = 13'(CT_US_0);
      3'h1:    target = 13'(CT_US_1);
      3'h2:    target = 13'(CT_US_2);
      3'h3:    target = 13'(CT_US_3);
      3'h4:    target = 13'(CT_US_4);
      3'h5:    target = 13'(CT_US_5);
      3'h6:    target = 13'(CT_US_6);
      default: target = 13'(CT_US_7);
    endcase
  end

  // A microsecond prescaler keeps the counter narrow instead of counting a million cycles.
  always_comb begin
    pre_d  = pre_q;
    us_d   = us_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start_i) begin
      pre_d = 8'h00;
      us_d  = 13'h0000;
      run_d = 1'b1;
    end else if (run_q) begin
      if (pre_q == 8'(US_DIV - 1)) begin
        pre_d = 8'h00;
        us_d  = us_q + 13'h0001;
        if (us_q + 13'h0001 >= target) begin
          run_d  = 1'b0;
          done_d = 1'b1;
        end
      end else begin
        pre_d = pre_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_q  <= 8'h00;
      us_q   <= 13'h0000;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      us_q   <= us_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

  assign done_o = done_q;

endmodule : pmas_conv_timer

// ==== verilog/pmas_sequencer.sv ====
// Top of the measurement sequencer with its Wishbone register file.
//
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
module pmas_sequencer
  import pmas_pkg::*;
#(
  parameter int US_DIV = US_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Converter samples from the analog front end
  input  wire logic [15:0] bus_sample_i,
  input  wire logic [15:0] shunt_sample_i,
  input  wire logic [11:0] temp_sample_i,
  // Status
  output logic             busy_o
);

  typedef enum logic [1:0] {
    PMAS_ST_IDLE = 2'b00,
    PMAS_ST_CONV = 2'b01,
    PMAS_ST_NEXT = 2'b10,
    PMAS_ST_DONE = 2'b11
  } pmas_state_e;

  pmas_setup_s   setup_q, setup_d;
  pmas_results_s res_q, res_d;
  pmas_state_e   st_q, st_d;
  pmas_chan_e    ch_q, ch_d;
  logic          arm_q, arm_d;
  logic [10:0]   cnt_q, cnt_d;
  logic          phase_q, phase_d;
  logic          busy_q;
  logic          ack_q, ack_d;
  logic [31:0]   rdat_q, rdat_d;
  logic          tstart, tdone;
  logic [2:0]    tcode;
  logic [10:0]   navg;
  logic [3:0]    ashift;
  logic          acc_clr, bus_add, cur_add, tmp_add;
  logic [15:0]   bus_mean, cur_mean, tmp_mean;
  logic          ch_bus_en, ch_cur_en, ch_tmp_en, mode_run;
  logic [3:0]    widx;
  logic [31:0]   pw_full;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode; reserved codes behave as shutdown.
  always_comb begin
    mode_run  = 1'b0;
    case (setup_q.mode)
      4'h1, 4'h4, 4'h5, 4'h6, 4'h7: mode_run = 1'b1;
      4'h9, 4'hc, 4'hd, 4'he, 4'hf: mode_run = 1'b1;
      default:                      mode_run = 1'b0;
    endcase
    ch_bus_en = mode_run & setup_q.mode[MODE_BUS_BIT];
    ch_cur_en = mode_run & setup_q.mode[MODE_CURR_BIT];
    ch_tmp_en = mode_run & setup_q.mode[MODE_TEMP_BIT];
    case (setup_q.sample_averaging_count)
      3'h0: begin
        navg   = 11'h001;
        ashift = 4'h0;
      end
      3'h1: begin
        navg   = 11'h004;
        ashift = 4'h2;
      end
      3'h2: begin
        navg   = 11'h010;
        ashift = 4'h4;
      end
      3'h3: begin
        navg   = 11'h040;
        ashift = 4'h6;
      end
      3'h4: begin
        navg   = 11'h080;
        ashift = 4'h7;
      end
      3'h5: begin
        navg   = 11'h100;
        ashift = 4'h8;
      end
      3'h6: begin
        navg   = 11'h200;
        ashift = 4'h9;
      end
      default: begin
        navg   = 11'h400;
        ashift = 4'ha;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register bus; writes and reads are answered one cycle after the request.
  always_comb begin
    setup_d = setup_q;
    arm_d   = arm_q;
    ack_d   = 1'b0;
    rdat_d  = rdat_q;
    widx    = wb_adr_i[5:ADDR_LSB];
    // A re-arm written in the same cycle overrides this clear, so no trigger is lost.
    if (st_q == PMAS_ST_DONE && !setup_q.mode[MODE_CONT_BIT]) begin
      arm_d = 1'b0;
    end
    if (wb_cyc_i && wb_stb_i && !ack_q) begin
      ack_d  = 1'b1;
      rdat_d = 32'h0000_0000;
      if (wb_we_i) begin
        if (widx == REG_SETUP_IDX) begin
          if (wb_sel_i[0]) setup_d[7:0]  = wb_dat_i[7:0];
          if (wb_sel_i[1]) setup_d[15:8] = wb_dat_i[15:8];
          if (wb_sel_i[1]) arm_d = 1'b1;
        end
      end else begin
        case (widx)
          REG_SETUP_IDX: rdat_d = {16'h0000, setup_q};
          REG_BUSV_IDX:  rdat_d = {16'h0000, res_q.bus_voltage};
          REG_TEMP_IDX:  rdat_d = {16'h0000, res_q.die_temperature, 4'h0};
          REG_CURR_IDX:  rdat_d = {16'h0000, res_q.current};
          REG_POWER_IDX: rdat_d = {8'h00, res_q.power};
          default:       rdat_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      setup_q <= SETUP_RESET;
      arm_q   <= 1'b1;
      ack_q   <= 1'b0;
      rdat_q  <= 32'h0000_0000;
    end else begin
      setup_q <= setup_d;
      arm_q   <= arm_d;
      ack_q   <= ack_d;
      rdat_q  <= rdat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel order is bus, current, temperature; current spends shunt then temperature time.
  function automatic pmas_chan_e next_chan(input pmas_chan_e c, input logic cur_en,
                                           input logic tmp_en);
    pmas_chan_e n;
    n = PMAS_CH_BUS;
    if (c == PMAS_CH_BUS && cur_en) begin
      n = PMAS_CH_CURR;
    end else if (c != PMAS_CH_TEMP && tmp_en) begin
      n = PMAS_CH_TEMP;
    end else begin
      n = PMAS_CH_BUS;
    end
    return n;
  endfunction : next_chan

  always_comb begin
    st_d    = st_q;
    ch_d    = ch_q;
    cnt_d   = cnt_q;
    phase_d = phase_q;
    tstart  = 1'b0;
    acc_clr = 1'b0;
    bus_add = 1'b0;
    cur_add = 1'b0;
    tmp_add = 1'b0;
    res_d   = res_q;
    pw_full = 32'(bus_mean) * 32'($unsigned(cur_mean[15] ? -cur_mean : cur_mean));
    case (ch_q)
      PMAS_CH_BUS:  tcode = setup_q.bus_voltage_conv_time;
      PMAS_CH_CURR: tcode = phase_q ? setup_q.temperature_conv_time
                                    : setup_q.shunt_voltage_conv_time;
      default:      tcode = setup_q.temperature_conv_time;
    endcase
    case (st_q)
      PMAS_ST_IDLE: begin
        if (mode_run && arm_q) begin
          acc_clr = 1'b1;
          cnt_d   = 11'd0;
          phase_d = 1'b0;
          ch_d    = ch_bus_en ? PMAS_CH_BUS
                  : next_chan(PMAS_CH_BUS, ch_cur_en, ch_tmp_en);
          tstart  = 1'b1;
          st_d    = PMAS_ST_CONV;
        end
      end
      PMAS_ST_CONV: begin
        if (!mode_run) begin
          st_d = PMAS_ST_IDLE;
        end else if (tdone) begin
          if (ch_q == PMAS_CH_CURR && !phase_q) begin
            phase_d = 1'b1;
            tstart  = 1'b1;
          end else begin
            phase_d = 1'b0;
            bus_add = (ch_q == PMAS_CH_BUS);
            cur_add = (ch_q == PMAS_CH_CURR);
            tmp_add = (ch_q == PMAS_CH_TEMP);
            st_d    = PMAS_ST_NEXT;
          end
        end
      end
      PMAS_ST_NEXT: begin
        st_d   = PMAS_ST_CONV;
        tstart = 1'b1;
        ch_d   = next_chan(ch_q, ch_cur_en, ch_tmp_en);
        if (next_chan(ch_q, ch_cur_en, ch_tmp_en) == PMAS_CH_BUS && !ch_bus_en) begin
          ch_d = next_chan(PMAS_CH_BUS, ch_cur_en, ch_tmp_en);
        end
        // A round ends when the last enabled channel has been sampled.
        if ((ch_q == PMAS_CH_TEMP) || (ch_q == PMAS_CH_CURR && !ch_tmp_en)
            || (ch_q == PMAS_CH_BUS && !ch_cur_en && !ch_tmp_en)) begin
          cnt_d = cnt_q + 11'd1;
          if (cnt_q + 11'd1 == navg) begin
            st_d   = PMAS_ST_DONE;
            tstart = 1'b0;
          end
        end
      end
      PMAS_ST_DONE: begin
        if (ch_bus_en) res_d.bus_voltage = bus_mean[15] ? 16'h0000 : bus_mean;
        if (ch_tmp_en) res_d.die_temperature = tmp_mean[11:0];
        if (ch_cur_en) res_d.current = cur_mean;
        if (ch_cur_en) res_d.power = pw_full[31:8];
        st_d = PMAS_ST_IDLE;
      end
      default: st_d = PMAS_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q    <= PMAS_ST_IDLE;
      ch_q    <= PMAS_CH_BUS;
      cnt_q   <= 11'd0;
      phase_q <= 1'b0;
      res_q   <= '0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      ch_q    <= ch_d;
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
      res_q   <= res_d;
      busy_q  <= (st_d != PMAS_ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  pmas_conv_timer #(
    .US_DIV (US_DIV)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tstart),
    .code_i  (tcode),
    .done_o  (tdone)
  );

  pmas_averager #(.W(16)) u_mean_bus (
    .clk_i (clk_i), .rst_i (rst_i), .clear_i (acc_clr), .add_i (bus_add),
    .sample_i (bus_sample_i), .shift_i (ashift), .mean_o (bus_mean)
  );

  pmas_averager #(.W(16)) u_mean_cur (
    .clk_i (clk_i), .rst_i (rst_i), .clear_i (acc_clr), .add_i (cur_add),
    .sample_i (shunt_sample_i), .shift_i (ashift), .mean_o (cur_mean)
  );

  pmas_averager #(.W(16)) u_mean_tmp (
    .clk_i (clk_i), .rst_i (rst_i), .clear_i (acc_clr), .add_i (tmp_add),
    .sample_i ({{4{temp_sample_i[11]}}, temp_sample_i}), .shift_i (ashift),
    .mean_o (tmp_mean)
  );

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign busy_o   = busy_q;

endmodule : pmas_sequencer
